// >>> hw/gpc_consts.svh
// constants for the pin-6 boot configuration block
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

`define GPC_CLK_HZ          25000000
`define GPC_CNT_W           20
`define GPC_IDX_W           15

// register indices, byte address is four times the index
`define GPC_IDX_CFG         15'h781f
`define GPC_IDX_CHECK       15'h7827
`define GPC_IDX_IRQ_STAT    15'h7830
`define GPC_IDX_IRQ_CLR     15'h7831
`define GPC_IDX_IRQ_EN      15'h7832
`define GPC_IDX_PIN_CTRL    15'h7833
`define GPC_IDX_PIN_STAT    15'h7834

// configuration word layout
`define GPC_B_DIR           15
`define GPC_F_PULL          14:13
`define GPC_B_MODE          12
`define GPC_B_DOM           11
`define GPC_B_POL           10
`define GPC_B_OD            9
`define GPC_B_ENA           8
`define GPC_F_FN            7:4
`define GPC_F_THR           3:1
`define GPC_CFG_RST         16'ha40a
`define GPC_CHECK_RST       16'h0000
`define GPC_CHECK_VALUE     16'ha596

`define GPC_PULL_NONE       2'h0
`define GPC_PULL_DOWN       2'h1
`define GPC_PULL_UP         2'h2

// input function codes
`define GPC_IN_GPIO_LONG    4'h0
`define GPC_IN_GPIO         4'h1
`define GPC_IN_ONOFF        4'h2
`define GPC_IN_SLPWK        4'h3
`define GPC_IN_SLPWK_LONG   4'h4
`define GPC_IN_SLEEP        4'h5
`define GPC_IN_PWRON        4'h6
`define GPC_IN_WDOG         4'h7
`define GPC_IN_VS1          4'h8
`define GPC_IN_VS2          4'h9
`define GPC_IN_HWEN1        4'ha
`define GPC_IN_HWEN2        4'hb
`define GPC_IN_HWC1         4'hc
`define GPC_IN_HWC2         4'hd
`define GPC_IN_HWC1_LONG    4'he
`define GPC_IN_HWC2_LONG    4'hf

// output function codes, 5 to 7 reserved
`define GPC_OUT_GPIO        4'h0
`define GPC_OUT_CLK32K      4'h1
`define GPC_OUT_ON          4'h2
`define GPC_OUT_SLEEP       4'h3
`define GPC_OUT_CHANGE      4'h4
`define GPC_OUT_VOLTAGE_SCALE_INPUT1_DONE   4'h8
`define GPC_OUT_VOLTAGE_SCALE_INPUT2_DONE   4'h9
`define GPC_OUT_EXT_EN1     4'ha
`define GPC_OUT_EXT_EN2     4'hb
`define GPC_OUT_SUP_GOOD    4'hc
`define GPC_OUT_CONV_OK     4'hd
`define GPC_OUT_EXTCLK      4'he
`define GPC_OUT_AUXRST      4'hf

// timing
`define GPC_DEB_NORMAL_US   2000
`define GPC_DEB_LONG_US     20000
`define GPC_DEB_NORMAL_CYC  (`GPC_DEB_NORMAL_US * (`GPC_CLK_HZ / 1000000))
`define GPC_DEB_LONG_CYC    (`GPC_DEB_LONG_US * (`GPC_CLK_HZ / 1000000))
`define GPC_OSC_HZ          32768
`define GPC_EXTCLK_HZ       2000000
`define GPC_HALF_OSC_CYC    (`GPC_CLK_HZ / (2 * `GPC_OSC_HZ))
`define GPC_HALF_EXT_CYC    (`GPC_CLK_HZ / (2 * `GPC_EXTCLK_HZ))

// supply-good threshold in millivolts
`define GPC_THR_BASE_MV     12'h0af0
`define GPC_THR_STEP_MV     12'h0064

// interrupt status layout
`define GPC_IRQ_W           3
`define GPC_IRQ_EDGE        0
`define GPC_IRQ_CHK_FAIL    1
`define GPC_IRQ_CHK_PASS    2

`endif

// >>> hw/gpc_pkg.sv
// types of the pin-6 boot configuration block
`include "gpc_consts.svh"
package gpc_pkg;

  typedef enum logic {
    GPC_BUS_IDLE,
    GPC_BUS_ACK
  } gpc_bus_e;

  typedef struct packed {
    gpc_bus_e                  bus;
    logic [15:0]               cfg;
    logic [15:0]               check;
    logic [`GPC_IRQ_W-1:0]     irq_stat;
    logic [`GPC_IRQ_W-1:0]     irq_en;
    logic                      out_val;
    logic [31:0]               rdata;
    logic                      sync1;
    logic                      sync2;
    logic                      sync3;
    logic                      deb;
    logic [`GPC_CNT_W-1:0]     deb_cnt;
    logic                      asserted_q;
    logic [15:0]               in_hit;
    logic [`GPC_CNT_W-1:0]     osc_cnt;
    logic                      osc;
    logic [`GPC_CNT_W-1:0]     ext_cnt;
    logic                      ext;
    logic                      pad_out;
    logic                      pad_oe_n;
    logic                      on_grant;
    logic                      on_reject;
  } gpc_state_s;

endpackage

// >>> hw/gpc_pin6_cfg.sv
// pin-6 boot configuration, function mux, debounce and check word
//
// Notes on behaviour
// - drive enable low tri-states; direction bit15 input
// - pull code 00 none, 01 down, 10 up
// - edge mode bit12: single edge or both
// - bit11 selects digital I/O or main supply
// - polarity bit10: 0 active low, 1 high
// - bit9: 0 push-pull, 1 open-drain output
// - input code 0 long debounce, 1 normal
// - input codes 2-6 power and sleep requests
// - input codes 7-15 watchdog, scaling, hardware controls
// - output codes 0-4 gpio, 32.768kHz, states
// - output codes 8-13 done, enables, supply good
// - output 14 is 2MHz clock, 15 reset
// - threshold field selects 2.8V to 3.5V
// - dev mode ON request needs check word A596h
`timescale 1ns/1ps
`include "gpc_consts.svh"

module gpc_pin6_cfg #(
  parameter logic [`GPC_CNT_W-1:0] DEB_NORMAL_CYC = `GPC_CNT_W'(`GPC_DEB_NORMAL_CYC),
  parameter logic [`GPC_CNT_W-1:0] DEB_LONG_CYC   = `GPC_CNT_W'(`GPC_DEB_LONG_CYC),
  parameter int                    ADDR_W         = 17
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   irq,
  input  wire logic              pad_in,
  output logic                   pad_out,
  output logic                   pad_oe_n,
  output logic                   pull_up_en,
  output logic                   pull_down_en,
  output logic                   io_supply_sel,
  output logic      [2:0]        supply_good_threshold,
  output logic      [11:0]       threshold_mv,
  input  wire logic              dev_mode,
  input  wire logic              on_request,
  output logic                   on_grant,
  output logic                   on_reject,
  input  wire logic              on_state,
  input  wire logic              sleep_state,
  input  wire logic              state_change,
  input  wire logic              voltage_scale_input1_done,
  input  wire logic              voltage_scale_input2_done,
  input  wire logic              ext_pwr_en1,
  input  wire logic              ext_pwr_en2,
  input  wire logic              supply_good,
  input  wire logic              converter_power_ok,
  input  wire logic              aux_reset,
  output logic                   gpio_in_level,
  output logic                   pwr_onoff_req,
  output logic                   sleep_wake_req,
  output logic                   sleep_req,
  output logic                   power_on_req,
  output logic                   wdog_reset_req,
  output logic                   voltage_scale_input1,
  output logic                   voltage_scale_input2,
  output logic                   hw_enable1,
  output logic                   hw_enable2,
  output logic                   hw_control1,
  output logic                   hw_control2
);

  localparam logic [`GPC_CNT_W-1:0] HALF_OSC = `GPC_CNT_W'(`GPC_HALF_OSC_CYC);
  localparam logic [`GPC_CNT_W-1:0] HALF_EXT = `GPC_CNT_W'(`GPC_HALF_EXT_CYC);

  localparam gpc_pkg::gpc_state_s ST_RST = '{
    bus:        gpc_pkg::GPC_BUS_IDLE,
    cfg:        `GPC_CFG_RST,
    check:      `GPC_CHECK_RST,
    pad_oe_n:   1'b1,
    default:    '0
  };

  gpc_pkg::gpc_state_s st;
  gpc_pkg::gpc_state_s next_st;

  // register hit at a word-aligned byte address
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [`GPC_IDX_W-1:0] idx);
    reg_hit = (addr == ADDR_W'({idx, 2'b00}));
  endfunction

  // byte-lane write into a 16-bit register held in the low lanes
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0]  be);
    wr16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // input codes that use the long debounce time
  function automatic logic is_long(input logic [3:0] fn);
    is_long = (fn == `GPC_IN_GPIO_LONG) || (fn == `GPC_IN_SLPWK_LONG) ||
              (fn == `GPC_IN_HWC1_LONG) || (fn == `GPC_IN_HWC2_LONG);
  endfunction

  function automatic logic [11:0] thr_mv(input logic [2:0] code);
    thr_mv = 12'(`GPC_THR_BASE_MV + `GPC_THR_STEP_MV * {9'h000, code});
  endfunction

  logic                  req;
  logic                  dir_in;
  logic                  enabled;
  logic                  asserted;
  logic                  out_src;
  logic                  out_lvl;
  logic                  chk_pass;
  logic [`GPC_IRQ_W-1:0] events;
  logic [`GPC_IRQ_W-1:0] irq_clr;
  logic [`GPC_CNT_W-1:0] deb_limit;
  logic [31:0]           rd_mux;

  assign req = avs_read | avs_write;

  always_comb begin
    next_st = st;

    dir_in  = st.cfg[`GPC_B_DIR];
    enabled = st.cfg[`GPC_B_ENA];

    // pad input: three stages, a change counts once stages two and three agree
    next_st.sync1 = pad_in;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;

    deb_limit = is_long(st.cfg[`GPC_F_FN]) ? DEB_LONG_CYC : DEB_NORMAL_CYC;
    if ((st.sync2 == st.sync3) && (st.sync3 != st.deb)) begin
      if (st.deb_cnt + `GPC_CNT_W'(1) >= deb_limit) begin
        next_st.deb     = st.sync3;
        next_st.deb_cnt = '0;
      end else begin
        next_st.deb_cnt = st.deb_cnt + `GPC_CNT_W'(1);
      end
    end else begin
      next_st.deb_cnt = '0;
    end

    asserted = st.cfg[`GPC_B_POL] ? st.deb : ~st.deb;
    next_st.asserted_q = asserted;

    // input function list only while the pin is an enabled input
    next_st.in_hit = '0;
    if (enabled && dir_in && asserted) begin
      next_st.in_hit[st.cfg[`GPC_F_FN]] = 1'b1;
    end

    events = '0;
    // single mode fires on the asserting edge, whose sense follows polarity
    if (enabled && dir_in) begin
      if (st.cfg[`GPC_B_MODE]) begin
        events[`GPC_IRQ_EDGE] = asserted != st.asserted_q;
      end else begin
        events[`GPC_IRQ_EDGE] = asserted && !st.asserted_q;
      end
    end

    // free-running dividers; the pin picks them up mid-phase on a function change
    if (st.osc_cnt >= HALF_OSC - `GPC_CNT_W'(1)) begin
      next_st.osc_cnt = '0;
      next_st.osc     = ~st.osc;
    end else begin
      next_st.osc_cnt = st.osc_cnt + `GPC_CNT_W'(1);
    end
    if (st.ext_cnt >= HALF_EXT - `GPC_CNT_W'(1)) begin
      next_st.ext_cnt = '0;
      next_st.ext     = ~st.ext;
    end else begin
      next_st.ext_cnt = st.ext_cnt + `GPC_CNT_W'(1);
    end

    case (st.cfg[`GPC_F_FN])
      `GPC_OUT_GPIO:      out_src = st.out_val;
      `GPC_OUT_CLK32K:    out_src = st.osc;
      `GPC_OUT_ON:        out_src = on_state;
      `GPC_OUT_SLEEP:     out_src = sleep_state;
      `GPC_OUT_CHANGE:    out_src = state_change;
      `GPC_OUT_VOLTAGE_SCALE_INPUT1_DONE: out_src = voltage_scale_input1_done;
      `GPC_OUT_VOLTAGE_SCALE_INPUT2_DONE: out_src = voltage_scale_input2_done;
      `GPC_OUT_EXT_EN1:   out_src = ext_pwr_en1;
      `GPC_OUT_EXT_EN2:   out_src = ext_pwr_en2;
      `GPC_OUT_SUP_GOOD:  out_src = supply_good;
      `GPC_OUT_CONV_OK:   out_src = converter_power_ok;
      `GPC_OUT_EXTCLK:    out_src = st.ext;
      `GPC_OUT_AUXRST:    out_src = aux_reset;
      default:            out_src = 1'b0;
    endcase
    out_lvl = st.cfg[`GPC_B_POL] ? out_src : ~out_src;

    if (!enabled || dir_in) begin
      next_st.pad_oe_n = 1'b1;
      next_st.pad_out  = 1'b0;
    end else if (st.cfg[`GPC_B_OD]) begin
      // open drain only ever pulls low; a high level is left to the pull-up
      next_st.pad_oe_n = out_lvl;
      next_st.pad_out  = 1'b0;
    end else begin
      next_st.pad_oe_n = 1'b0;
      next_st.pad_out  = out_lvl;
    end

    // outside development mode the check word is not consulted
    chk_pass          = (st.check == `GPC_CHECK_VALUE);
    next_st.on_grant  = on_request && (!dev_mode || chk_pass);
    next_st.on_reject = on_request && dev_mode && !chk_pass;
    events[`GPC_IRQ_CHK_FAIL] = on_request && dev_mode && !chk_pass;
    events[`GPC_IRQ_CHK_PASS] = on_request && dev_mode && chk_pass;

    rd_mux = '0;
    if (reg_hit(avs_address, `GPC_IDX_CFG)) begin
      rd_mux[15:0] = st.cfg;
    end else if (reg_hit(avs_address, `GPC_IDX_CHECK)) begin
      rd_mux[15:0] = st.check;
    end else if (reg_hit(avs_address, `GPC_IDX_IRQ_STAT)) begin
      rd_mux[`GPC_IRQ_W-1:0] = st.irq_stat;
    end else if (reg_hit(avs_address, `GPC_IDX_IRQ_EN)) begin
      rd_mux[`GPC_IRQ_W-1:0] = st.irq_en;
    end else if (reg_hit(avs_address, `GPC_IDX_PIN_CTRL)) begin
      rd_mux[0] = st.out_val;
    end else if (reg_hit(avs_address, `GPC_IDX_PIN_STAT)) begin
      rd_mux[2:0] = {pad_oe_n, asserted, st.deb};
    end

    irq_clr = '0;
    case (st.bus)
      gpc_pkg::GPC_BUS_IDLE: begin
        if (req) begin
          next_st.bus   = gpc_pkg::GPC_BUS_ACK;
          next_st.rdata = avs_read ? rd_mux : 32'h0000_0000;
        end
      end
      gpc_pkg::GPC_BUS_ACK: begin
        next_st.bus = gpc_pkg::GPC_BUS_IDLE;
        if (avs_write) begin
          if (reg_hit(avs_address, `GPC_IDX_CFG)) begin
            next_st.cfg = wr16(st.cfg, avs_writedata, avs_byteenable);
          end
          if (reg_hit(avs_address, `GPC_IDX_CHECK)) begin
            next_st.check = wr16(st.check, avs_writedata, avs_byteenable);
          end
          if (reg_hit(avs_address, `GPC_IDX_IRQ_EN) && avs_byteenable[0]) begin
            next_st.irq_en = avs_writedata[`GPC_IRQ_W-1:0];
          end
          if (reg_hit(avs_address, `GPC_IDX_IRQ_CLR) && avs_byteenable[0]) begin
            irq_clr = avs_writedata[`GPC_IRQ_W-1:0];
          end
          if (reg_hit(avs_address, `GPC_IDX_PIN_CTRL) && avs_byteenable[0]) begin
            next_st.out_val = avs_writedata[0];
          end
        end
      end
      default: next_st.bus = gpc_pkg::GPC_BUS_IDLE;
    endcase

    // a new event outranks a clear written in the same cycle
    next_st.irq_stat = (st.irq_stat & ~irq_clr) | events;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign avs_waitrequest       = req && (st.bus == gpc_pkg::GPC_BUS_IDLE);
  assign avs_readdata          = st.rdata;
  assign irq                   = |(st.irq_stat & st.irq_en);
  assign pad_out               = st.pad_out;
  assign pad_oe_n              = st.pad_oe_n;
  assign pull_up_en            = st.cfg[`GPC_F_PULL] == `GPC_PULL_UP;
  assign pull_down_en          = st.cfg[`GPC_F_PULL] == `GPC_PULL_DOWN;
  assign io_supply_sel         = st.cfg[`GPC_B_DOM];
  assign supply_good_threshold = st.cfg[`GPC_F_THR];
  assign threshold_mv          = thr_mv(st.cfg[`GPC_F_THR]);
  assign on_grant              = st.on_grant;
  assign on_reject             = st.on_reject;
  assign gpio_in_level         = st.in_hit[`GPC_IN_GPIO_LONG] | st.in_hit[`GPC_IN_GPIO];
  assign pwr_onoff_req         = st.in_hit[`GPC_IN_ONOFF];
  assign sleep_wake_req        = st.in_hit[`GPC_IN_SLPWK] | st.in_hit[`GPC_IN_SLPWK_LONG];
  assign sleep_req             = st.in_hit[`GPC_IN_SLEEP];
  assign power_on_req          = st.in_hit[`GPC_IN_PWRON];
  assign wdog_reset_req        = st.in_hit[`GPC_IN_WDOG];
  assign voltage_scale_input1  = st.in_hit[`GPC_IN_VS1];
  assign voltage_scale_input2  = st.in_hit[`GPC_IN_VS2];
  assign hw_enable1            = st.in_hit[`GPC_IN_HWEN1];
  assign hw_enable2            = st.in_hit[`GPC_IN_HWEN2];
  assign hw_control1           = st.in_hit[`GPC_IN_HWC1] | st.in_hit[`GPC_IN_HWC1_LONG];
  assign hw_control2           = st.in_hit[`GPC_IN_HWC2] | st.in_hit[`GPC_IN_HWC2_LONG];

endmodule // gpc_pin6_cfg

// >>> verification/gpc_pin_model.sv
// pin model: resolves the pad level from the device drive, an outside driver and the pulls
`timescale 1ns/1ps

module gpc_pin_model (
  input  wire logic clk_sys,
  input  wire logic ext_drive,
  input  wire logic ext_level,
  input  wire logic pad_out,
  input  wire logic pad_oe_n,
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  output logic      pad_in
);
  logic last;

  always_ff @(posedge clk_sys) begin
    last <= pad_in;
  end

  // a floating pad flips every cycle so a stale level never looks driven
  always_comb begin
    if (!pad_oe_n) pad_in = pad_out;
    else if (ext_drive) pad_in = ext_level;
    else if (pull_up_en) pad_in = 1'b1;
    else if (pull_down_en) pad_in = 1'b0;
    else pad_in = ~last;
  end
endmodule // gpc_pin_model

// >>> verification/gpc_pin6_cfg_props.sv
// concurrent checks on the pin-6 boot configuration block ports
`timescale 1ns/1ps

module gpc_pin6_cfg_props (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        pad_oe_n,
  input wire logic        pull_up_en,
  input wire logic        pull_down_en,
  input wire logic [2:0]  supply_good_threshold,
  input wire logic [11:0] threshold_mv,
  input wire logic        dev_mode,
  input wire logic        on_request,
  input wire logic        on_grant,
  input wire logic        on_reject,
  input wire logic        gpio_in_level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_pull_exclusive: assert property (!(pull_up_en && pull_down_en))
    else $error("pull-up and pull-down both enabled");
  a_thr_millivolts: assert property (threshold_mv == 12'(2800 + 100 * supply_good_threshold))
    else $error("threshold millivolts do not follow the code");
  a_on_answer: assert property (on_request |=> (on_grant != on_reject))
    else $error("on request not answered by exactly one pulse");
  a_answer_cause: assert property ((on_grant || on_reject) |-> $past(on_request))
    else $error("on answer without a request");
  a_plain_grant: assert property (on_request && !dev_mode |=> on_grant)
    else $error("request outside development mode not granted");
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus held longer than one wait state");
  a_rdata_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_input_tristate: assert property (gpio_in_level |-> pad_oe_n)
    else $error("pad driven while used as input");
endmodule // gpc_pin6_cfg_props

bind gpc_pin6_cfg gpc_pin6_cfg_props gpc_pin6_cfg_props_i (.clk_sys, .rst_n, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .pad_oe_n, .pull_up_en, .pull_down_en,
  .supply_good_threshold, .threshold_mv, .dev_mode, .on_request, .on_grant, .on_reject,
  .gpio_in_level);

// >>> verification/gpc_pin6_cfg_tb_top.sv
// self-checking bench for the pin-6 boot configuration block
`timescale 1ns/1ps

module gpc_pin6_cfg_tb_top;
  localparam logic [16:0] A_CFG = 17'h1_e07c, A_CHK = 17'h1_e09c, A_STAT = 17'h1_e0c0;
  localparam logic [16:0] A_CLR = 17'h1_e0c4, A_EN = 17'h1_e0c8, A_PIN = 17'h1_e0cc;
  localparam int FI [16] = '{0, 0, 1, 2, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 10, 11};
  logic        clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [16:0] avs_address = 17'h0_0000;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic        avs_waitrequest, irq, pad_in, pad_out, pad_oe_n, pull_up_en, pull_down_en;
  logic        io_supply_sel, on_grant, on_reject, dev_mode = 1'b0, on_request = 1'b0;
  logic        ext_drive = 1'b1, ext_level = 1'b0, p, o, g, lv;
  logic [2:0]  supply_good_threshold;
  logic [11:0] threshold_mv;
  logic [9:0]  src = 10'h000, sv;
  wire  [11:0] fo;
  logic [15:0] rd, cw;
  int          fail_count = 0, tests_run = 0, cyc = 0, n;
  integer      seed = 32'hf462_5c67;

  always #20 clk_sys = ~clk_sys;

  gpc_pin6_cfg #(.DEB_NORMAL_CYC(20'h0_0004), .DEB_LONG_CYC(20'h0_0008)) gpc_pin6_cfg_i (
    .clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .irq, .pad_in, .pad_out,
    .pad_oe_n, .pull_up_en, .pull_down_en, .io_supply_sel, .supply_good_threshold,
    .threshold_mv, .dev_mode, .on_request, .on_grant, .on_reject,
    .on_state(src[0]), .sleep_state(src[1]), .state_change(src[2]), .voltage_scale_input1_done(src[3]),
    .voltage_scale_input2_done(src[4]), .ext_pwr_en1(src[5]), .ext_pwr_en2(src[6]), .supply_good(src[7]),
    .converter_power_ok(src[8]), .aux_reset(src[9]), .gpio_in_level(fo[0]),
    .pwr_onoff_req(fo[1]), .sleep_wake_req(fo[2]), .sleep_req(fo[3]), .power_on_req(fo[4]),
    .wdog_reset_req(fo[5]), .voltage_scale_input1(fo[6]), .voltage_scale_input2(fo[7]),
    .hw_enable1(fo[8]), .hw_enable2(fo[9]), .hw_control1(fo[10]), .hw_control2(fo[11]));
  gpc_pin_model gpc_pin_model_i (.clk_sys, .ext_drive, .ext_level, .pad_out, .pad_oe_n,
    .pull_up_en, .pull_down_en, .pad_in);

  function automatic logic osrc(input logic [3:0] c, input logic [9:0] s, input logic gv);
    case (c)
      4'h2, 4'h3, 4'h4: return s[c - 4'h2];
      4'h5, 4'h6, 4'h7: return 1'b0;
      4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd: return s[c - 4'h5];
      4'hf: return s[9];
      default: return gv;
    endcase
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // an edge always passes before a new request, so a strobe is never lowered and raised at once
  task automatic bus(input logic wr, input logic [16:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic pin(input logic lvl, input int i, input logic e);
    @(posedge clk_sys);
    ext_level <= lvl;
    n = 0;
    while (fo[i] !== e && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("fn_level", e, fo[i]);
  endtask

  task automatic toggles(input logic [15:0] c, input int k, input int lo, input int hi);
    logic last;
    bus(1'b1, A_CFG, c);
    repeat (3) @(negedge clk_sys);
    last = pad_out;
    n = 0;
    repeat (k) begin
      @(negedge clk_sys);
      if (pad_out !== last) n++;
      last = pad_out;
    end
    chk("toggles", 1, n >= lo && n <= hi);
  endtask

  task automatic on(input logic dm, input logic [1:0] exp);
    @(posedge clk_sys);
    on_request <= 1'b1;
    dev_mode <= dm;
    @(posedge clk_sys);
    on_request <= 1'b0;
    @(negedge clk_sys);
    chk("on_answer", exp, {on_grant, on_reject});
  endtask

  task automatic conclude();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b0, A_CFG, 16'h0000);
    chk("cfg_reset", 32'h0000_a40a, rd);
    bus(1'b0, A_CHK, 16'h0000);
    chk("check_reset", 32'h0000_0000, rd);
    chk("pins_reset", 32'h0000_0005, {pull_up_en, pull_down_en, io_supply_sel, pad_oe_n});
    bus(1'b0, 17'h1_e100, 16'h0000);
    chk("unmapped", 32'h0000_0000, rd);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      cw = {1'b1, i[1:0], 1'b0, 1'($random(seed)), 7'h00, i[2:0], 1'b0};
      bus(1'b1, A_CFG, cw);
      repeat (2) @(negedge clk_sys);
      chk("pull", {i[1:0] == 2'h2, i[1:0] == 2'h1}, {pull_up_en, pull_down_en});
      chk("supply_sel", cw[11], io_supply_sel);
      chk("threshold", {i[2:0], 12'(2800 + 100 * i)}, {supply_good_threshold, threshold_mv});
    end
    $display("test config fields done");
    for (int c = 0; c < 16; c++) if (c != 1 && c != 14) begin
      p = 1'($random(seed));
      o = 1'($random(seed));
      g = 1'($random(seed));
      sv = 10'($random(seed));
      @(posedge clk_sys);
      src <= sv;
      bus(1'b1, A_PIN, {15'h0000, g});
      bus(1'b1, A_CFG, {5'h04, p, o, 1'b1, c[3:0], 4'ha});
      repeat (2) @(negedge clk_sys);
      lv = osrc(c[3:0], sv, g) ~^ p;
      chk("pad", o ? {lv, 1'b0} : {1'b0, lv}, {pad_oe_n, pad_out});
    end
    bus(1'b1, A_CFG, 16'h240a);
    repeat (2) @(negedge clk_sys);
    chk("tristate", 1, pad_oe_n);
    toggles(16'h25ea, 120, 19, 21);
    toggles(16'h251a, 1600, 4, 5);
    $display("test outputs done");
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, A_CFG, {5'h14, 3'b101, c[3:0], 4'ha});
      pin(1'b1, FI[c], 1'b1);
      chk("fn_onehot", 12'h001 << FI[c], fo);
      pin(1'b0, FI[c], 1'b0);
    end
    $display("test inputs done");
    bus(1'b1, A_CFG, 16'ha51a);
    bus(1'b1, A_EN, 16'h0007);
    bus(1'b1, A_CLR, 16'h0007);
    pin(1'b1, 0, 1'b1);
    repeat (2) @(negedge clk_sys);
    chk("irq_rise", 1, irq);
    bus(1'b1, A_EN, 16'h0000);
    repeat (2) @(negedge clk_sys);
    chk("irq_masked", 0, irq);
    bus(1'b1, A_CLR, 16'h0001);
    pin(1'b0, 0, 1'b0);
    repeat (2) @(negedge clk_sys);
    bus(1'b0, A_STAT, 16'h0000);
    chk("stat_fall_single", 0, rd);
    bus(1'b1, A_CFG, 16'hb51a);
    pin(1'b1, 0, 1'b1);
    bus(1'b1, A_CLR, 16'h0001);
    pin(1'b0, 0, 1'b0);
    repeat (2) @(negedge clk_sys);
    bus(1'b0, A_STAT, 16'h0000);
    chk("stat_fall_both", 1, rd);
    bus(1'b1, A_CFG, 16'ha11a);
    pin(1'b0, 0, 1'b1);
    pin(1'b1, 0, 1'b0);
    // released pad: only the pull-down is left to set the level
    bus(1'b1, A_CFG, 16'ha51a);
    @(posedge clk_sys);
    ext_drive <= 1'b0;
    pin(1'b1, 0, 1'b0);
    $display("test edges done");
    bus(1'b1, A_CLR, 16'h0007);
    on(1'b0, 2'b10);
    on(1'b1, 2'b01);
    bus(1'b1, A_CHK, 16'ha596);
    on(1'b1, 2'b10);
    bus(1'b1, A_CHK, 16'ha596 ^ (16'h0001 << 4'($random(seed))));
    on(1'b1, 2'b01);
    bus(1'b0, A_STAT, 16'h0000);
    chk("on_status", 6, rd);
    $display("test check word done");
    conclude();
  end
endmodule // gpc_pin6_cfg_tb_top
